// *** bench/srv_media_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module srv_media_model (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       media_req,
    input  wire logic [8:0] fail_at,
    input  wire logic [1:0] gap,
    output logic            media_ack,
    output logic            media_unc,
    output logic            media_idnf,
    output logic            media_abrt
);
    logic [1:0] wait_cnt;
    logic [8:0] index;
    logic       junk;
    // Error lines toggle outside an acknowledge so stale values are never trusted.
    assign media_ack  = media_req && wait_cnt == gap;
    assign media_unc  = media_ack ? index == fail_at : junk;
    assign media_idnf = media_ack ? 1'b0 : ~junk;
    assign media_abrt = media_ack ? 1'b0 : junk;
    always_ff @(posedge clock)
    begin
        junk     <= reset ? 1'b0 : ~junk;
        wait_cnt <= (reset || !media_req || media_ack) ? 2'h0 : wait_cnt + 2'h1;
        index    <= (reset || !media_req) ? 9'h0 : index + 9'(media_ack);
    end
endmodule
`default_nettype wire

// *** bench/srv_top_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "srv_defs.svh"
`define SRV_CHECK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("unexpected at %0t: got %h want %h", $time, got, exp); \
        end \
    end
module srv_top_test;
    import srv_pkg::*;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [8:0]  fail_at = 9'h1ff;
    logic [1:0]  gap = 2'h0;
    logic        hreadyout, hresp, media_req, media_xfer, media_urgent, media_nonseq;
    logic        cmd_done, media_ack, media_unc, media_idnf, media_abrt;
    logic [2:0]  media_stream;
    srv_word_t   hrdata;
    srv_lba_t    media_lba;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          a;
    srv_lba_t    l;
    logic [5:0]  f;

    // A raised floor of three microseconds shows up as a later stop than two.
    srv_top #(.MIN_LIMIT_US(3)) i_dut (.clock(clock), .reset(reset), .clock_en(1'b1),
        .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .haddr(haddr),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .media_req(media_req), .media_lba(media_lba),
        .media_xfer(media_xfer), .media_urgent(media_urgent), .media_nonseq(media_nonseq),
        .media_stream(media_stream), .media_ack(media_ack), .media_unc(media_unc),
        .media_idnf(media_idnf), .media_abrt(media_abrt), .cmd_done(cmd_done));
    srv_media_model i_media (.clock(clock), .reset(reset), .media_req(media_req),
        .fail_at(fail_at), .gap(gap), .media_ack(media_ack), .media_unc(media_unc),
        .media_idnf(media_idnf), .media_abrt(media_abrt));

    always #12.5 clock = ~clock;

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic ahb(input logic wr_en, input logic [7:0] ad, input logic [7:0] d,
                       output srv_word_t q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr_en;
        haddr <= {24'h0, ad};
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        srv_word_t q;
        ahb(1'b1, ad, d, q);
    endtask

    task automatic chk(input logic [7:0] ad, input logic [7:0] exp);
        srv_word_t q;
        ahb(1'b0, ad, 8'h0, q);
        `SRV_CHECK(q, {24'h0, exp})
    endtask

    // Previous byte goes first, since each write pushes current into previous.
    task automatic load(input logic [15:0] ft, input logic [15:0] c, input srv_lba_t s,
                        input logic [7:0] dh);
        wr(`SRV_OFS_FEATURE, ft[15:8]);
        wr(`SRV_OFS_FEATURE, ft[7:0]);
        wr(`SRV_OFS_COUNT, c[15:8]);
        wr(`SRV_OFS_COUNT, c[7:0]);
        wr(`SRV_OFS_SECTOR, s[31:24]);
        wr(`SRV_OFS_SECTOR, s[7:0]);
        wr(`SRV_OFS_CYL_LOW, s[39:32]);
        wr(`SRV_OFS_CYL_LOW, s[15:8]);
        wr(`SRV_OFS_CYL_HIGH, s[47:40]);
        wr(`SRV_OFS_CYL_HIGH, s[23:16]);
        wr(`SRV_OFS_DEV_HEAD, dh);
    endtask

    task automatic run(input logic [7:0] cmd);
        int n = 0;
        a = 0;
        l = 48'h0;
        wr(`SRV_OFS_CMD_STAT, cmd);
        while (cmd_done !== 1'b1 && n < 5000)
        begin
            @(posedge clock);
            n++;
            if (media_req === 1'b1 && a == 0)
                {l, f} = {media_lba, media_xfer, media_urgent, media_nonseq, media_stream};
            if (media_ack === 1'b1)
                a++;
        end
        `SRV_CHECK(cmd_done, 1'b1)
    endtask

    task automatic stream_plain();
        load(16'h00a5, 16'h0101, 48'h0a0b_0c0d_0e0f, 8'he0);
        run(`SRV_CMD_STREAM_PIO);
        `SRV_CHECK(a, 257)
        `SRV_CHECK(l, 48'h0a0b_0c0d_0e0f)
        `SRV_CHECK(f, 6'h3d)
        chk(`SRV_OFS_CMD_STAT, 8'h50);
        chk(`SRV_OFS_CYL_LOW, 8'h0f);
        wr(`SRV_OFS_CONTROL, 8'h80);
        chk(`SRV_OFS_SECTOR, 8'h0c);
        chk(`SRV_OFS_CYL_HIGH, 8'h0a);
        wr(`SRV_OFS_CONTROL, 8'h00);
        chk(`SRV_OFS_FEATURE, 8'h00);
        chk(8'h30, 8'h00);
    endtask

    task automatic verify_all();
        load(16'h0, 16'h0, 48'h09ab_cdef, 8'h49);
        run(8'h40);
        `SRV_CHECK(a, 256)
        `SRV_CHECK(l, 48'h09ab_cdef)
        `SRV_CHECK(f[5], 1'b0)
        chk(`SRV_OFS_COUNT, 8'h00);
        chk(`SRV_OFS_SECTOR, 8'hee);
    endtask

    task automatic verify_fail();
        gap <= 2'h1;
        fail_at <= 9'h2;
        load(16'h0, 16'h5, 48'h10, 8'h40);
        run(8'h41);
        `SRV_CHECK(a, 3)
        chk(`SRV_OFS_COUNT, 8'h03);
        chk(`SRV_OFS_SECTOR, 8'h12);
        chk(`SRV_OFS_CMD_STAT, 8'h51);
        chk(`SRV_OFS_ERROR, 8'h40);
    endtask

    task automatic cont_error();
        gap <= 2'h0;
        fail_at <= 9'h1;
        load(16'h0040, 16'h4, 48'h20, 8'he0);
        run(`SRV_CMD_STREAM_PIO);
        `SRV_CHECK(a, 4)
        chk(`SRV_OFS_CMD_STAT, 8'h70);
        chk(`SRV_OFS_ERR_LOG, 8'h40);
        chk(`SRV_OFS_ERROR, 8'h00);
        chk(`SRV_OFS_SECTOR, 8'h21);
        chk(`SRV_OFS_COUNT, 8'h03);
    endtask

    task automatic cont_timeout();
        gap <= 2'h3;
        fail_at <= 9'h1ff;
        load(16'h0240, 16'h64, 48'h40, 8'he0);
        run(`SRV_CMD_STREAM_PIO);
        `SRV_CHECK(a > 24 && a < 40, 1'b1)
        chk(`SRV_OFS_CMD_STAT, 8'h70);
        chk(`SRV_OFS_ERR_LOG, 8'h01);
        load(16'h0210, 16'h64, 48'h40, 8'he0);
        run(`SRV_CMD_STREAM_PIO);
        `SRV_CHECK(l, 48'h5e)
        chk(`SRV_OFS_ERROR, 8'h01);
    endtask

    initial
    begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        stream_plain();
        verify_all();
        verify_fail();
        cont_error();
        cont_timeout();
        give_verdict();
    end
endmodule
`default_nettype wire

// *** include/srv_defs.svh ***
`ifndef SRV_DEFS_SVH
`define SRV_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SRV_OFS_FEATURE   8'h00
`define SRV_OFS_COUNT     8'h04
`define SRV_OFS_SECTOR    8'h08
`define SRV_OFS_CYL_LOW   8'h0c
`define SRV_OFS_CYL_HIGH  8'h10
`define SRV_OFS_DEV_HEAD  8'h14
`define SRV_OFS_CMD_STAT  8'h18
`define SRV_OFS_ERROR     8'h1c
`define SRV_OFS_CONTROL   8'h20
`define SRV_OFS_ERR_LOG   8'h24
`define SRV_OFS_TIME_UNIT 8'h28
`define SRV_OFS_STREAM    8'h2c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SRV_FT_PRIORITY   7
`define SRV_FT_CONT       6
`define SRV_FT_NONSEQ     5
`define SRV_FT_RESUME     4
`define SRV_ST_BUSY       7
`define SRV_ST_READY      6
`define SRV_ST_FAULT      5
`define SRV_ST_DSC        4
`define SRV_ST_ERR        0
`define SRV_ER_UNC        6
`define SRV_ER_IDNF       4
`define SRV_ER_ABRT       2
`define SRV_ER_EXPIRED    0
`define SRV_CTL_HOB       7
`define SRV_DH_LBA        6

// ----------------------------------------------------------------------------
// Commands, reset values and timing
// ----------------------------------------------------------------------------
`define SRV_CMD_STREAM_PIO 8'h2b
`define SRV_CMD_STREAM_DMA 8'h2a
`define SRV_CMD_VERIFY_HI  7'h20
`define SRV_RST_BYTE       8'h00
`define SRV_RST_UNIT       32'h0000_0001
`define SRV_TICK_NS        1000
`define SRV_CLK_NS         25
`define SRV_US_CYCLES      ((`SRV_TICK_NS + `SRV_CLK_NS - 1) / `SRV_CLK_NS)

`endif

// *** include/srv_pkg.sv ***
`default_nettype none
package srv_pkg;

    typedef enum logic [1:0] {srv_idle, srv_run, srv_fin} srv_state_e;
    typedef logic [31:0] srv_word_t;
    typedef logic [47:0] srv_lba_t;

endpackage
`default_nettype wire

// *** src/srv_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "srv_defs.svh"

// Function
// (RL1) Urgent flag asks fastest completion, always inside the active time limit.
// (RL2) Continuous read mode never aborts the streamed read on errors.
// (RL3) Continuous mode errors: move everything, end with fault set, error clear, log.
// (RL4) Continuous mode timeout: stop, fault set, error clear, expiry logged.
// (RL5) Host may hint that the next streamed read is not sequential.
// (RL6) Resume flag starts at the stream's last reported error address.
// (RL7) Three-bit stream identifier selects the stream and its settings.
// (RL8) Limit in microseconds is upper feature byte times reported time unit.
// (RL9) Zero byte uses stream default; zero or unset default means no limit.
// (RL10) Timing runs from command register write to command completion.
// (RL11) Limits below the built-in minimum are raised to that minimum.
// (RL12) Streamed read count is sixteen bits; zero means 65536 sectors.
// (RL13) Start address is assembled from current and previous address bytes.
// (RL14) Error address returns in same layout; high byte select picks upper bytes.
// (RL15) Expiry bit zero of error register is set when the limit runs out.
// (RL16) Fault status bit five marks errors; address and count describe bad run.
// (RL17) Continuous mode error bits go to the error log, not error register.
// (RL18) Codes 40h and 41h both verify sectors and send no data.
// (RL19) Uncorrectable error ends sector verify at the failing sector.
// (RL20) Sector verify count is eight bits; zero means 256 sectors.
// (RL21) Verify address is 28-bit block address or cylinder, head, sector.
// (RL22) Verify reports sectors left unverified and address of last sector processed.
// (RL23) Timer is a microsecond prescaler feeding a down-counter loaded at command write.
module srv_top #(
    parameter int            MIN_LIMIT_US = 1000
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        clock_en,
    input  wire logic        hsel,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] haddr,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output srv_pkg::srv_word_t hrdata,
    output logic             media_req,
    output srv_pkg::srv_lba_t media_lba,
    output logic             media_xfer,
    output logic             media_urgent,
    output logic             media_nonseq,
    output logic [2:0]       media_stream,
    input  wire logic        media_ack,
    input  wire logic        media_unc,
    input  wire logic        media_idnf,
    input  wire logic        media_abrt,
    output logic             cmd_done
);
    import srv_pkg::*;

    // ------------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------------
    logic [7:0]  tf_cur [6];
    logic [7:0]  tf_prev [6];
    logic [7:0]  control;
    logic [7:0]  error_byte;
    logic [7:0]  err_log;
    logic [31:0] time_unit;
    logic [7:0]  dflt_limit [8];
    srv_lba_t    err_lba_mem [8];
    logic        busy;
    logic        fault;
    logic        err_flag;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        addr_ok;
    logic        cmd_go;
    srv_state_e  state;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel && hready && htrans[1];
    assign busy      = (state != srv_idle);
    assign cmd_go    = wr_pend && (wr_addr == `SRV_OFS_CMD_STAT) && !busy;

    function automatic logic [7:0] read_byte(input logic [7:0] a);
        logic hob;
        hob = control[`SRV_CTL_HOB];
        read_byte = 8'h00;
        if (a < `SRV_OFS_CMD_STAT)
        begin
            // Count, address and device/head bytes; the feature byte is write only.
            if (a != `SRV_OFS_FEATURE)
                read_byte = hob ? tf_prev[a[4:2]] : tf_cur[a[4:2]];
        end
        else if (a == `SRV_OFS_CMD_STAT)
            read_byte = {busy, 1'b1, fault, 1'b1, 3'b000, err_flag};
        else if (a == `SRV_OFS_ERROR)
            read_byte = error_byte;
        else if (a == `SRV_OFS_CONTROL)
            read_byte = control;
        else if (a == `SRV_OFS_ERR_LOG)
            read_byte = err_log;
    endfunction

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata  <= 32'h0;
        end
        else if (clock_en && hready)
        begin
            wr_pend <= addr_ok && hwrite && (hsize == 3'b010);
            wr_addr <= haddr[7:0];
            if (addr_ok && !hwrite)
            begin
                if (haddr[7:0] == `SRV_OFS_TIME_UNIT)
                    hrdata <= time_unit;
                else
                    hrdata <= {24'h0, read_byte(haddr[7:0])};
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            control   <= `SRV_RST_BYTE;
            time_unit <= `SRV_RST_UNIT;
            for (int i = 0; i < 8; i++)
                dflt_limit[i] <= `SRV_RST_BYTE;
        end
        else if (clock_en && wr_pend)
        begin
            if (wr_addr == `SRV_OFS_CONTROL)
                control <= hwdata[7:0];
            if (wr_addr == `SRV_OFS_TIME_UNIT)
                time_unit <= hwdata;
            // Stream defaults: bits 10:8 pick the stream, bits 7:0 the limit byte.
            if (wr_addr == `SRV_OFS_STREAM)
                dflt_limit[hwdata[10:8]] <= hwdata[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Command start decode
    // ------------------------------------------------------------------------
    logic [7:0]  cmd;
    logic        is_stream;
    logic        is_verify;
    logic [2:0]  sid;
    logic [7:0]  lim_byte;
    logic [39:0] lim_us;
    logic [16:0] start_cnt;
    srv_lba_t    start_lba;

    assign cmd       = hwdata[7:0];
    assign is_stream = (cmd == `SRV_CMD_STREAM_PIO) || (cmd == `SRV_CMD_STREAM_DMA);
    // (RL18) Retry bit ignored
    assign is_verify = (cmd[7:1] == `SRV_CMD_VERIFY_HI);
    // (RL7) Stream selection
    assign sid       = tf_cur[0][2:0];
    // (RL9) Default limit fallback
    assign lim_byte  = (tf_prev[0] != 8'h00) ? tf_prev[0] : dflt_limit[sid];
    // (RL8) Limit product
    assign lim_us    = {32'h0, lim_byte} * {8'h0, time_unit};

    always_comb
    begin
        start_cnt = 17'h0;
        start_lba = '0;
        if (is_stream)
        begin
            // (RL12) Sixteen-bit count
            start_cnt = ({tf_prev[1], tf_cur[1]} == 16'h0) ? 17'h10000
                                                           : {1'b0, tf_prev[1], tf_cur[1]};
            // (RL13) 48-bit address assembly
            start_lba = {tf_prev[4], tf_prev[3], tf_prev[2], tf_cur[4], tf_cur[3], tf_cur[2]};
            // (RL6) Resume at last error
            if (tf_cur[0][`SRV_FT_RESUME])
                start_lba = err_lba_mem[sid];
        end
        else
        begin
            // (RL20) Eight-bit count
            start_cnt = (tf_cur[1] == 8'h00) ? 17'h00100 : {9'h0, tf_cur[1]};
            // (RL21) Block or cylinder/head/sector packing
            if (tf_cur[5][`SRV_DH_LBA])
                start_lba = {20'h0, tf_cur[5][3:0], tf_cur[4], tf_cur[3], tf_cur[2]};
            else
                start_lba = {20'h0, tf_cur[4], tf_cur[3], tf_cur[5][3:0], tf_cur[2]};
        end
    end

    // ------------------------------------------------------------------------
    // Completion timer
    // ------------------------------------------------------------------------
    localparam logic [5:0] US_LAST = 6'(`SRV_US_CYCLES - 1);
    logic [5:0]  presc;
    logic [39:0] us_left;
    logic        lim_on;
    logic        timeout;

    assign timeout = lim_on && (us_left == 40'h0) && (state == srv_run);

    // (RL23) Prescaler and down-counter
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            presc   <= 6'h0;
            us_left <= 40'h0;
            lim_on  <= 1'b0;
        end
        else if (clock_en)
        begin
            if (cmd_go)
            begin
                // (RL10) Timing starts at command write
                presc  <= 6'h0;
                lim_on <= is_stream && (lim_byte != 8'h00) && (time_unit != 32'h0);
                // (RL11) Minimum limit
                us_left <= (lim_us < 40'(MIN_LIMIT_US)) ? 40'(MIN_LIMIT_US) : lim_us;
            end
            else if (state == srv_run && us_left != 40'h0)
            begin
                presc <= (presc == US_LAST) ? 6'h0 : presc + 6'h1;
                if (presc == US_LAST)
                    us_left <= us_left - 40'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------------
    logic        cont;
    logic        in_stream;
    logic [16:0] remain;
    logic        seen_err;
    srv_lba_t    first_lba;
    srv_lba_t    res_lba;
    logic [15:0] res_cnt;
    logic        res_load;
    logic [2:0]  cur_err;
    logic [7:0]  err_bits;

    assign cur_err  = {media_unc, media_idnf, media_abrt};
    assign err_bits = {1'b0, media_unc, 1'b0, media_idnf, 1'b0, media_abrt, 2'b00};
    assign media_req = (state == srv_run);
    assign media_xfer = (state == srv_run) && in_stream;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state <= srv_idle;
            cont <= 1'b0;
            in_stream <= 1'b0;
            remain <= 17'h0;
            seen_err <= 1'b0;
            first_lba <= '0;
            media_lba <= '0;
            res_lba <= '0;
            res_cnt <= 16'h0;
            res_load <= 1'b0;
            fault <= 1'b0;
            err_flag <= 1'b0;
            error_byte <= 8'h00;
            err_log <= 8'h00;
            media_urgent <= 1'b0;
            media_nonseq <= 1'b0;
            media_stream <= 3'h0;
            cmd_done <= 1'b0;
            for (int i = 0; i < 8; i++)
                err_lba_mem[i] <= '0;
        end
        else if (clock_en)
        begin
            cmd_done <= 1'b0;
            unique case (state)
                srv_idle:
                begin
                    res_load <= 1'b0;
                    if (cmd_go)
                    begin
                        fault <= 1'b0;
                        err_flag <= 1'b0;
                        error_byte <= 8'h00;
                        err_log <= 8'h00;
                        seen_err <= 1'b0;
                        if (is_stream || is_verify)
                        begin
                            state <= srv_run;
                            in_stream <= is_stream;
                            cont <= is_stream && tf_cur[0][`SRV_FT_CONT];
                            // (RL1) Urgent request to media
                            media_urgent <= is_stream && tf_cur[0][`SRV_FT_PRIORITY];
                            media_nonseq <= is_stream && tf_cur[0][`SRV_FT_NONSEQ];
                            media_stream <= sid;
                            remain <= start_cnt;
                            media_lba <= start_lba;
                        end
                        else
                        begin
                            err_flag <= 1'b1;
                            error_byte <= 8'h04;
                            cmd_done <= 1'b1;
                        end
                    end
                end
                srv_run:
                begin
                    if (timeout)
                    begin
                        state <= srv_fin;
                        res_load <= 1'b1;
                        res_lba <= seen_err ? first_lba : media_lba;
                        res_cnt <= remain[15:0];
                        err_lba_mem[media_stream] <= seen_err ? first_lba : media_lba;
                        if (cont)
                        begin
                            // (RL4) Timeout in continuous mode
                            fault <= 1'b1;
                            err_log <= err_log | 8'h01;
                        end
                        else
                        begin
                            // (RL15) Expiry bit
                            err_flag <= 1'b1;
                            error_byte <= error_byte | 8'h01;
                        end
                    end
                    else if (media_ack)
                    begin
                        if (cur_err != 3'b000 && cont)
                        begin
                            // (RL17) Error bits into the log
                            err_log <= err_log | err_bits;
                            if (!seen_err)
                                first_lba <= media_lba;
                            seen_err <= 1'b1;
                        end
                        if (cur_err != 3'b000 && !cont)
                        begin
                            // (RL19) Verify stops at the failing sector
                            state <= srv_fin;
                            res_load <= 1'b1;
                            res_lba <= media_lba;
                            res_cnt <= in_stream ? 16'h0001 : {8'h00, remain[7:0]};
                            err_flag <= 1'b1;
                            error_byte <= err_bits;
                            if (in_stream)
                                err_lba_mem[media_stream] <= media_lba;
                        end
                        else
                        begin
                            // (RL2) Continuous mode keeps going
                            media_lba <= media_lba + 48'h1;
                            remain <= remain - 17'h1;
                            if (remain == 17'h1)
                            begin
                                state <= srv_fin;
                                res_load <= 1'b1;
                                if (in_stream && (seen_err || cur_err != 3'b000))
                                begin
                                    // (RL3) Full transfer, fault ending
                                    fault <= 1'b1;
                                    res_lba <= seen_err ? first_lba : media_lba;
                                    res_cnt <= 16'(media_lba - (seen_err ? first_lba
                                                                         : media_lba) + 48'h1);
                                    err_lba_mem[media_stream] <= seen_err ? first_lba
                                                                          : media_lba;
                                end
                                else
                                begin
                                    // (RL22) Last sector and nothing left
                                    res_lba <= media_lba;
                                    res_cnt <= 16'h0;
                                end
                            end
                        end
                    end
                end
                srv_fin:
                begin
                    state <= srv_idle;
                    res_load <= 1'b0;
                    cmd_done <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Task-file registers
    // ------------------------------------------------------------------------
    // Host writes push the current byte into the previous one, as the 48-bit
    // commands need two writes per register.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            for (int i = 0; i < 6; i++)
            begin
                tf_cur[i]  <= `SRV_RST_BYTE;
                tf_prev[i] <= `SRV_RST_BYTE;
            end
        end
        else if (clock_en)
        begin
            if (state == srv_fin && res_load)
            begin
                // (RL14) Result address in the block-address layout, also after cylinder/head/sector verify
                tf_cur[2]  <= res_lba[7:0];
                tf_cur[3]  <= res_lba[15:8];
                tf_cur[4]  <= res_lba[23:16];
                tf_prev[2] <= res_lba[31:24];
                tf_prev[3] <= res_lba[39:32];
                tf_prev[4] <= res_lba[47:40];
                // (RL16) Count of possibly bad sectors
                tf_cur[1]  <= res_cnt[7:0];
                tf_prev[1] <= res_cnt[15:8];
                if (!in_stream)
                    tf_cur[5][3:0] <= res_lba[27:24];
            end
            else if (wr_pend && wr_addr < `SRV_OFS_CMD_STAT && !busy)
            begin
                tf_prev[wr_addr[4:2]] <= tf_cur[wr_addr[4:2]];
                tf_cur[wr_addr[4:2]]  <= hwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking chk_cb @(posedge clock iff clock_en);
    endclocking
    default disable iff (reset);

    chk_start_busy: assert property (cmd_go && (is_stream || is_verify) |=> busy) // (RL10)
        else $error("command write did not raise busy");
    chk_stream_count: assert property ( // (RL12)
        cmd_go && is_stream && {tf_prev[1], tf_cur[1]} == 16'h0 |=> remain == 17'h10000)
        else $error("zero stream count is not 65536");
    chk_verify_count: assert property ( // (RL20)
        cmd_go && is_verify && tf_cur[1] == 8'h00 |=> remain == 17'h00100)
        else $error("zero verify count is not 256");
    chk_limit_floor: assert property (cmd_go && is_stream |=> us_left >= 40'(MIN_LIMIT_US)) // (RL11)
        else $error("time limit below minimum");
    chk_verify_nodata: assert property (cmd_go && is_verify |=> media_req && !media_xfer) // (RL18)
        else $error("verify moved data to host");
    chk_cont_timeout: assert property ( // (RL4)
        timeout && cont |=> fault && !err_flag && err_log[0] ##1 !busy)
        else $error("continuous timeout ending wrong");
    chk_plain_timeout: assert property (timeout && !cont |=> error_byte[0] && err_flag) // (RL15)
        else $error("expiry bit not set");
    chk_cont_no_abort: assert property ( // (RL2)
        state == srv_run && cont && media_ack && !timeout && remain > 17'h1 |=> state == srv_run)
        else $error("continuous read aborted early");
    chk_verify_stop: assert property ( // (RL19)
        state == srv_run && !in_stream && media_ack && media_unc && !timeout
        |=> state == srv_fin && err_flag ##1 !busy)
        else $error("verify did not stop at failing sector");
endmodule

`default_nettype wire
